/* File: gtc_consts.svh */
// Constants for the general purpose input trigger block.
// Assumes inclusion by the package and the design file by bare name.
`ifndef GTC_CONSTS_SVH
`define GTC_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define GTC_ADDR_W        4
`define GTC_OFS_MODE      4'h0
`define GTC_OFS_PORTCFG   4'h1
`define GTC_OFS_SOURCE    4'h2
`define GTC_OFS_STATUS    4'h3
`define GTC_OFS_DOUT      4'h4

// ----------------------------------------------------------------
// Field layout of a port's 5-bit configuration slice
// ----------------------------------------------------------------
`define GTC_CFG_W         5
`define GTC_CFG_FUNC_LSB  0
`define GTC_CFG_TYPE_BIT  3
`define GTC_CFG_POL_BIT   4

// ----------------------------------------------------------------
// Reset values and the port-driven source
// ----------------------------------------------------------------
`define GTC_CFG_RST       5'h00
`define GTC_SRC_RST       4'h0
`define GTC_PORT_SRC      4'hF

`endif

/* File: gtc_pkg.sv */
// Types for the general purpose input trigger block.
// Assumes gtc_consts.svh on the include path.
`include "gtc_consts.svh"

package gtc_pkg;

  // Port function; none is the reset choice
  typedef enum logic [2:0]
  {
    GTC_FN_NONE     = 3'h0,
    GTC_FN_INSERT   = 3'h1,
    GTC_FN_OVERRIDE = 3'h2,
    GTC_FN_RESTORE  = 3'h3,
    GTC_FN_TIMECODE = 3'h4
  } gtc_func_e;

  // One port's settings
  typedef struct packed
  {
    logic      pol_high;   // High/rising when set
    logic      level;      // Level trigger when set
    gtc_func_e func;       // Port function
  } gtc_cfg_s;

  // Register port request
  typedef struct packed
  {
    logic [`GTC_ADDR_W-1:0] addr;
    logic [31:0]            wdata;
    logic                   wr;
    logic                   rd;
  } gtc_req_s;

endpackage : gtc_pkg

/* File: gtc_trigger.sv */
// General purpose input trigger logic for a bank of ports.
// Assumes one system clock; pins arrive asynchronously.
//
// Overview of operation
// - Function none: port gives no trigger or timecode
// - Insertion function follows global encode/decode mode
// - Encode makes ports inputs, decode makes all but timecode ports outputs
// - Override trigger selects port-driven source
// - Restore edge trigger returns original source
// - Timecode function routes port to timecode line
// - Edge type fires once per edge
// - Level type fires while level held
// - High polarity: rising edge or high level
// - Low polarity: falling edge or low level
`timescale 1ns/1ps
`include "gtc_consts.svh"

module gtc_trigger #(
  parameter int NPORTS = 4
) (
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  input  wire gtc_pkg::gtc_req_s      req_i,
  output logic [31:0]                 rdata_o,
  input  wire logic [NPORTS-1:0]      gpi_in_i,
  output logic [NPORTS-1:0]           gpi_out_o,
  output logic [NPORTS-1:0]           gpi_oe_o,
  output logic [NPORTS-1:0]           insert_trig_o,
  output logic [3:0]                  trig_source_o,
  output logic                        timecode_o
);
  import gtc_pkg::*;

  // Settings word holds 5 bits per port, so at most 6 ports fit
  if (NPORTS < 1 || NPORTS > 6)
  begin : g_bad_nports
    $error("NPORTS must be 1 to 6");
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic                  decode_r;      // 0 encode, 1 decode
  gtc_cfg_s              cfg_r [NPORTS]; // Per-port settings
  logic [3:0]            src_cfg_r;     // Configured source
  logic [3:0]            src_r;         // Source in effect
  logic [NPORTS-1:0]     dout_r;        // Decoder output levels
  logic [NPORTS-1:0]     sync1_r;       // First sync stage
  logic [NPORTS-1:0]     sync2_r;       // Second sync stage
  logic [NPORTS-1:0]     prev_r;        // Previous sample
  // Nets, as each generate pass drives its own slice
  wire [NPORTS-1:0]      fire;          // Per-port trigger
  wire [NPORTS-1:0]      ovr_fire;      // Override triggers
  wire [NPORTS-1:0]      rst_fire;      // Restore triggers
  wire [NPORTS-1:0]      ins_fire;      // Insertion triggers
  wire [NPORTS-1:0]      tc_sel;        // Timecode ports
  wire [31:0]            cfg_word;      // Packed settings view
  logic [31:0]           rdata_nxt;     // Read mux

  // ----------------------------------------------------------------
  // Input synchroniser and edge sampler
  // ----------------------------------------------------------------
  // Only sync2 is looked at; sync1 may be metastable
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
    end
    else
    begin
      sync1_r <= gpi_in_i;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // ----------------------------------------------------------------
  // Per-port trigger decode
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NPORTS; gi++)
    begin : g_port
      wire rise  = sync2_r[gi] & ~prev_r[gi];
      wire fall  = ~sync2_r[gi] & prev_r[gi];
      // Edge picks direction, level picks active value
      wire edge_hit = cfg_r[gi].pol_high ? rise : fall;
      wire lvl_hit  = cfg_r[gi].pol_high ? sync2_r[gi]
                                         : ~sync2_r[gi];
      // Triggers only fire in encode mode
      assign fire[gi] = ~decode_r &
                        (cfg_r[gi].level ? lvl_hit
                                         : edge_hit);
      // Function none never matches any use below
      assign ins_fire[gi] = fire[gi] &
                            (cfg_r[gi].func == GTC_FN_INSERT);
      assign ovr_fire[gi] = fire[gi] &
                            (cfg_r[gi].func == GTC_FN_OVERRIDE);
      // Restore acts on edge type only
      assign rst_fire[gi] = fire[gi] & ~cfg_r[gi].level &
                            (cfg_r[gi].func == GTC_FN_RESTORE);
      assign tc_sel[gi] = cfg_r[gi].func == GTC_FN_TIMECODE;
      assign cfg_word[gi*`GTC_CFG_W +: `GTC_CFG_W] = cfg_r[gi];
    end
  endgenerate
  if (NPORTS * `GTC_CFG_W < 32)
  begin : g_pad
    assign cfg_word[31:NPORTS*`GTC_CFG_W] = '0;
  end

  // ----------------------------------------------------------------
  // Register writes and source selection
  // ----------------------------------------------------------------
  wire wr_mode = req_i.wr & (req_i.addr == `GTC_OFS_MODE);
  wire wr_cfg  = req_i.wr & (req_i.addr == `GTC_OFS_PORTCFG);
  wire wr_src  = req_i.wr & (req_i.addr == `GTC_OFS_SOURCE);
  wire wr_dout = req_i.wr & (req_i.addr == `GTC_OFS_DOUT);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      decode_r  <= 1'b0;
      src_cfg_r <= `GTC_SRC_RST;
      dout_r    <= '0;
      for (int i = 0; i < NPORTS; i++)
        cfg_r[i] <= `GTC_CFG_RST;
    end
    else
    begin
      if (wr_mode)
        decode_r <= req_i.wdata[0];
      if (wr_src)
        src_cfg_r <= req_i.wdata[3:0];
      if (wr_dout)
        dout_r <= req_i.wdata[NPORTS-1:0];
      // Each port has its own slice of the word
      if (wr_cfg)
        for (int i = 0; i < NPORTS; i++)
          cfg_r[i] <= req_i.wdata[i*`GTC_CFG_W +: `GTC_CFG_W];
    end
  end

  // Override wins over restore if both fire together
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      src_r <= `GTC_SRC_RST;
    else if (|ovr_fire)
      src_r <= `GTC_PORT_SRC;
    else if (|rst_fire || wr_src)
      src_r <= wr_src ? req_i.wdata[3:0] : src_cfg_r;
  end

  // ----------------------------------------------------------------
  // Outputs and read data
  // ----------------------------------------------------------------
  assign rdata_nxt =
    (req_i.addr == `GTC_OFS_MODE)    ? {31'h0, decode_r} :
    (req_i.addr == `GTC_OFS_PORTCFG) ? cfg_word :
    (req_i.addr == `GTC_OFS_SOURCE)  ? {28'h0, src_r} :
    (req_i.addr == `GTC_OFS_STATUS)  ?
      {{(32-NPORTS){1'b0}}, sync2_r} :
    (req_i.addr == `GTC_OFS_DOUT)    ?
      {{(32-NPORTS){1'b0}}, dout_r} : 32'h0;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rdata_o       <= '0;
      gpi_out_o     <= '0;
      gpi_oe_o      <= '0;
      insert_trig_o <= '0;
      trig_source_o <= `GTC_SRC_RST;
      timecode_o    <= 1'b0;
    end
    else
    begin
      rdata_o <= req_i.rd ? rdata_nxt : 32'h0;
      // Decode drives all but timecode ports; timecode ports stay inputs
      gpi_oe_o  <= decode_r ? ~tc_sel : '0;
      gpi_out_o <= dout_r & ~tc_sel;
      insert_trig_o <= ins_fire;
      trig_source_o <= src_r;
      timecode_o <= |(sync2_r & tc_sel);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_edge_once: assert property (
    @(posedge clk_i) disable iff (reset_i)
    insert_trig_o[0] && !cfg_r[0].level |=> !insert_trig_o[0])
    else $error("edge trigger lasted two cycles");
  chk_decode_oe: assert property (
    @(posedge clk_i) disable iff (reset_i)
    decode_r && !tc_sel[0] |=> gpi_oe_o[0])
    else $error("decode mode left port undriven");
  chk_encode_oe: assert property (
    @(posedge clk_i) disable iff (reset_i)
    !decode_r |=> gpi_oe_o == '0)
    else $error("encode mode drove a port");
  chk_none_quiet: assert property (
    @(posedge clk_i) disable iff (reset_i)
    cfg_r[0].func == GTC_FN_NONE |=> !insert_trig_o[0])
    else $error("unconfigured port fired");
  chk_override_src: assert property (
    @(posedge clk_i) disable iff (reset_i)
    |ovr_fire |=> src_r == `GTC_PORT_SRC)
    else $error("override did not take source");
  chk_restore_src: assert property (
    @(posedge clk_i) disable iff (reset_i)
    |rst_fire && !(|ovr_fire) && !wr_src |=> src_r == $past(src_cfg_r))
    else $error("restore did not return source");
  chk_level_high: assert property (
    @(posedge clk_i) disable iff (reset_i)
    !decode_r && cfg_r[0].level && cfg_r[0].pol_high && sync2_r[0]
    && cfg_r[0].func == GTC_FN_INSERT |=> insert_trig_o[0])
    else $error("high level did not fire");
  chk_sync_delay: assert property (
    @(posedge clk_i) disable iff (reset_i)
    ##2 sync2_r == $past(gpi_in_i, 2))
    else $error("sync depth is not two");

endmodule : gtc_trigger

/* File: gtc_pin_drv.sv */
// Far-side equipment model driving the trigger input pins.
// Assumes the bench sets wanted levels; pins follow 3 ns late.
`timescale 1ns/1ps
module gtc_pin_drv #(
  parameter int N = 4
) (
  input  wire logic [N-1:0] want_i,
  output logic      [N-1:0] pins_o
);
  // Lag keeps pin edges off the clock edge, like a real pin
  assign #3 pins_o = want_i;
endmodule : gtc_pin_drv

/* File: gtc_trigger_tb.sv */
// Self-checking bench for the trigger block.
// Assumes gtc_pkg and gtc_pin_drv are compiled first.
`timescale 1ns/1ps
module gtc_trigger_tb;
  import gtc_pkg::*;
  // ----------------------------------------------------------------
  // Signals and expectation table
  // ----------------------------------------------------------------
  typedef struct {logic [4:0] cfg; logic from; int cls;
                  logic [3:0] src;} gtc_row_s;
  logic        clk_i, reset_i, timecode_o;
  gtc_req_s    req_i;
  logic [31:0] rdata_o, rd_v;
  logic [3:0]  want, pins, gpi_out_o, gpi_oe_o, insert_trig_o, trig_source_o;
  int          mismatches, checks_done, cnt;
  // Pulse class: 0 none, 1 single, 2 held
  gtc_row_s rows [8] = '{'{5'h00, 1'b1, 0, 4'h5}, '{5'h01, 1'b1, 1, 4'h5},
    '{5'h11, 1'b0, 1, 4'h5}, '{5'h01, 1'b0, 0, 4'h5},
    '{5'h19, 1'b0, 2, 4'h5}, '{5'h09, 1'b1, 2, 4'h5},
    '{5'h02, 1'b1, 0, 4'hF}, '{5'h04, 1'b1, 0, 4'h5}};
  gtc_pin_drv #(.N(4)) u_pins (.want_i(want), .pins_o(pins));
  gtc_trigger #(.NPORTS(4)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
    .req_i(req_i), .rdata_o(rdata_o), .gpi_in_i(pins),
    .gpi_out_o(gpi_out_o), .gpi_oe_o(gpi_oe_o),
    .insert_trig_o(insert_trig_o), .trig_source_o(trig_source_o),
    .timecode_o(timecode_o));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // One bus cycle; read data caught in the cycle after the strobe
  task automatic bus(input logic [3:0] a, input logic [31:0] d,
                     input logic w);
    req_i.addr <= a;
    req_i.wdata <= d;
    req_i.wr <= w;
    req_i.rd <= !w;
    @(posedge clk_i);
    req_i.wr <= 1'b0;
    req_i.rd <= 1'b0;
    #1 rd_v = rdata_o;
    @(posedge clk_i);
  endtask : bus
  // Counts cycles with port 0 insertion trigger high
  task automatic watch();
    cnt = 0;
    repeat (12)
    begin
      @(posedge clk_i);
      #1;
      // Unknown counts as a pulse so it can never slip through
      if (insert_trig_o[0] !== 1'b0)
        cnt++;
    end
  endtask : watch
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g);
    end
  endtask : chk
  task automatic summarize();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // ----------------------------------------------------------------
  // Clock, watchdog, sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = !clk_i;
  end
  // Whole run is a few hundred cycles; far margin before a hang
  initial
  begin
    #200000;
    mismatches++;
    summarize();
  end
  initial
  begin
    reset_i = 1'b1;
    req_i = '0;
    want = 4'h0;
    tick(8);
    reset_i <= 1'b0;
    tick(1);
    // Reset state and unmapped places all read zero
    for (int a = 0; a < 8; a++)
    begin
      bus(a[3:0], 32'h0, 1'b0);
      chk("reset read", 32'h0, rd_v);
    end
    chk("oe encode", 32'h0, 32'(gpi_oe_o));
    // Ordinary cases on port 0
    foreach (rows[i])
    begin
      want <= {4{rows[i].from}};
      tick(4);
      bus(4'h1, {27'h0, rows[i].cfg}, 1'b1);
      bus(4'h2, 32'h5, 1'b1);
      want[0] <= !rows[i].from;
      watch();
      // Two or more counted cycles mean the trigger was held
      if (cnt > 1)
        cnt = 2;
      chk("pulses", rows[i].cls, cnt);
      chk("source", 32'(rows[i].src), 32'(trig_source_o));
    end
    // Override, restore by edge and level, timecode, side by side
    want <= 4'h7;
    tick(4);
    bus(4'h1, 32'h22C62, 1'b1);
    bus(4'h2, 32'h5, 1'b1);
    // Each port's slice reads back as written; pins show once synced
    bus(4'h1, 32'h0, 1'b0);
    chk("cfg readback", 32'h22C62, rd_v);
    bus(4'h3, 32'h0, 1'b0);
    chk("status", 32'h7, rd_v);
    want[0] <= 1'b0;
    tick(6);
    chk("override", 32'hF, 32'(trig_source_o));
    bus(4'h2, 32'h0, 1'b0);
    chk("source read", 32'hF, rd_v);
    want[2] <= 1'b0;
    tick(6);
    chk("level restore", 32'hF, 32'(trig_source_o));
    want[1] <= 1'b0;
    tick(6);
    chk("edge restore", 32'h5, 32'(trig_source_o));
    chk("timecode lo", 32'h0, 32'(timecode_o));
    want[3] <= 1'b1;
    tick(6);
    chk("timecode hi", 32'h1, 32'(timecode_o));
    // Decode mode: ports drive outputs and triggers stay quiet
    want <= 4'hF;
    tick(4);
    bus(4'h1, 32'h21, 1'b1);
    bus(4'h0, 32'h1, 1'b1);
    bus(4'h4, 32'h5, 1'b1);
    want <= 4'h0;
    watch();
    chk("decode pulses", 32'h0, cnt);
    chk("oe decode", 32'hF, 32'(gpi_oe_o));
    chk("out decode", 32'h5, 32'(gpi_out_o));
    summarize();
  end
endmodule : gtc_trigger_tb
